// [pkg/plm_regs.vh]
`ifndef PLM_REGS_VH
`define PLM_REGS_VH

// register byte offsets
`define PLM_CTRL_OFS 8'h00
`define PLM_STAT_OFS 8'h04
`define PLM_IRQ_STS_OFS 8'h08
`define PLM_IRQ_CLR_OFS 8'h0c
`define PLM_IRQ_EN_OFS 8'h10

// control register fields
`define PLM_CTRL_LCK_EN_BIT 0
`define PLM_CTRL_PDN_BIT 1
`define PLM_CTRL_LRP_LSB 4
`define PLM_CTRL_LRP_MSB 7
`define PLM_CTRL_RST 32'h0000_0002

// lock status fields
`define PLM_STAT_COARSE_BIT 0
`define PLM_STAT_FINE_BIT 1

// interrupt status / clear / enable layout
`define PLM_IRQ_FINE_BIT 0
`define PLM_IRQ_COARSE_BIT 1
`define PLM_IRQ_LOSS_BIT 2
`define PLM_IRQ_W 3
`define PLM_IRQ_STS_RST 3'h0
`define PLM_IRQ_EN_RST 3'h0

// lock detector timing, in master clock periods
`define PLM_CHK_FIRST 7'd16
`define PLM_CHK_COARSE 7'd32
`define PLM_CHK_FINE 7'd64
`define PLM_CNT_W 7
`define PLM_FB_DIVIDE 24

// loss of reference timing: (period + 1) * 10 * 2 output clock periods
`define PLM_LOR_MULT_A 10
`define PLM_LOR_MULT_B 2
`define PLM_LOR_CNT_W 10

// interrupt vector the combined request is wired to
`define PLM_IRQ_VECTOR 11

// ahb-lite encodings
`define PLM_HTRANS_NONSEQ 2'b10
`define PLM_HSIZE_WORD 3'b010

`endif

// [core/plm_edge_sync.v]
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser followed by a rising edge detector
module plm_edge_sync (
  input wire clk,
  input wire rst_b,
  input wire async_in,
  output wire rise_pulse
);
  reg meta_r;
  reg sync_r;
  reg prev_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // one pulse per full input period, independent of duty cycle
  assign rise_pulse = sync_r & ~prev_r;
endmodule
`default_nettype wire

// [core/plm_monitor.v]
`timescale 1ns/1ps
`default_nettype none
`include "plm_regs.vh"

// How it works
// - detector runs only when enabled and powered
// - counts divided feedback and master clock edges
// - compares whole periods, rising edge to rising
// - checkpoints at 16, 32, 64 master cycles
// - match at 32 sets coarse lock
// - match at 64 sets fine lock
// - fine clears on any mismatch, coarse on a 32 mismatch; both on disable, reset
// - check at 64 restarts both counters
// - fine mismatch may leave coarse set
// - stopped reference raises loss interrupt
// - loss after (period+1)*10*2 clocks
// - three sources ORed into one request
// - enabled loss event wakes system from stop
// - registers clocked by bus clock
module plm_monitor #(
  parameter CNT_W = `PLM_CNT_W,
  parameter LOR_W = `PLM_LOR_CNT_W
) (
  input wire clk,
  input wire rst_b,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire ref_clk_in,
  input wire fb_clk_in,
  output wire pll_power_down,
  output wire coarse_lock_flag,
  output wire fine_lock_flag,
  output wire irq,
  output wire wake_req
);
  // clk is the running pll output; bus registers share it
  reg [31:0] ctrl_r;
  reg coarse_r;
  reg fine_r;
  reg [`PLM_IRQ_W-1:0] irq_sts_r;
  reg [`PLM_IRQ_W-1:0] irq_en_r;
  reg [CNT_W-1:0] mcnt_r;
  reg [CNT_W-1:0] fcnt_r;
  reg [LOR_W-1:0] lor_cnt_r;
  reg lor_hit_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;

  wire lock_monitor_enable;
  wire [3:0] loss_ref_period;
  wire det_active;
  wire ref_rise;
  wire fb_rise;
  wire [CNT_W-1:0] mcnt_inc;
  wire [CNT_W-1:0] fcnt_inc;
  wire chk_first;
  wire chk_coarse;
  wire chk_fine;
  wire counts_match;
  wire [LOR_W-1:0] lor_limit;
  wire [31:0] lor_limit_full;
  wire lor_event;
  wire coarse_change;
  wire fine_change;
  wire [`PLM_IRQ_W-1:0] irq_event;
  wire addr_phase;
  wire [31:0] wr_data;

  reg coarse_nxt;
  reg fine_nxt;
  reg [CNT_W-1:0] mcnt_nxt;
  reg [CNT_W-1:0] fcnt_nxt;

  // word-aligned register decode shared by read and write paths
  function [2:0] reg_sel;
    input [7:0] ofs;
    begin
      case (ofs)
        `PLM_CTRL_OFS: reg_sel = 3'h1;
        `PLM_STAT_OFS: reg_sel = 3'h2;
        `PLM_IRQ_STS_OFS: reg_sel = 3'h3;
        `PLM_IRQ_CLR_OFS: reg_sel = 3'h4;
        `PLM_IRQ_EN_OFS: reg_sel = 3'h5;
        default: reg_sel = 3'h0;
      endcase
    end
  endfunction

  assign lock_monitor_enable = ctrl_r[`PLM_CTRL_LCK_EN_BIT];
  assign pll_power_down = ctrl_r[`PLM_CTRL_PDN_BIT];
  assign loss_ref_period = ctrl_r[`PLM_CTRL_LRP_MSB:`PLM_CTRL_LRP_LSB];
  assign det_active = lock_monitor_enable & ~pll_power_down;

  // master clock from the pll reference, feedback is vco / 24 at the pll
  plm_edge_sync u_ref_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(ref_clk_in),
    .rise_pulse(ref_rise)
  );

  plm_edge_sync u_fb_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(fb_clk_in),
    .rise_pulse(fb_rise)
  );

  // counts include any edge arriving in the checkpoint cycle itself
  assign mcnt_inc = mcnt_r + {{(CNT_W-1){1'b0}}, ref_rise};
  assign fcnt_inc = (&fcnt_r) ? fcnt_r : fcnt_r + {{(CNT_W-1){1'b0}}, fb_rise};
  assign counts_match = (mcnt_inc == fcnt_inc);
  assign chk_first = ref_rise & (mcnt_inc == `PLM_CHK_FIRST);
  assign chk_coarse = ref_rise & (mcnt_inc == `PLM_CHK_COARSE);
  assign chk_fine = ref_rise & (mcnt_inc == `PLM_CHK_FINE);

  always @* begin
    coarse_nxt = coarse_r;
    fine_nxt = fine_r;
    mcnt_nxt = mcnt_inc;
    fcnt_nxt = fcnt_inc;
    if (!det_active) begin
      coarse_nxt = 1'b0;
      fine_nxt = 1'b0;
      mcnt_nxt = {CNT_W{1'b0}};
      fcnt_nxt = {CNT_W{1'b0}};
    end else if (chk_first) begin
      if (!counts_match) begin
        fine_nxt = 1'b0;
      end
    end else if (chk_coarse) begin
      coarse_nxt = counts_match;
      if (!counts_match) begin
        fine_nxt = 1'b0;
      end
    end else if (chk_fine) begin
      // coarse stays as it is when only the fine check fails
      fine_nxt = counts_match;
      mcnt_nxt = {CNT_W{1'b0}};
      fcnt_nxt = {CNT_W{1'b0}};
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coarse_r <= 1'b0;
      fine_r <= 1'b0;
      mcnt_r <= {CNT_W{1'b0}};
      fcnt_r <= {CNT_W{1'b0}};
    end else begin
      coarse_r <= coarse_nxt;
      fine_r <= fine_nxt;
      mcnt_r <= mcnt_nxt;
      fcnt_r <= fcnt_nxt;
    end
  end

  assign coarse_lock_flag = coarse_r;
  assign fine_lock_flag = fine_r;

  // loss of reference: count output clocks since the last reference edge
  // product formed at full width, then cut to the timer width on purpose
  assign lor_limit_full = ({28'h000_0000, loss_ref_period} + 32'h0000_0001)
                        * `PLM_LOR_MULT_A * `PLM_LOR_MULT_B;
  assign lor_limit = lor_limit_full[LOR_W-1:0];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lor_cnt_r <= {LOR_W{1'b0}};
      lor_hit_r <= 1'b0;
    end else if (pll_power_down || ref_rise) begin
      lor_cnt_r <= {LOR_W{1'b0}};
      lor_hit_r <= 1'b0;
    end else if (!lor_hit_r) begin
      lor_cnt_r <= lor_cnt_r + {{(LOR_W-1){1'b0}}, 1'b1};
      if (lor_cnt_r + {{(LOR_W-1){1'b0}}, 1'b1} == lor_limit) begin
        lor_hit_r <= 1'b1;
      end
    end
  end

  // one event per stretch without reference
  assign lor_event = ~pll_power_down & ~ref_rise & ~lor_hit_r
                   & (lor_cnt_r + {{(LOR_W-1){1'b0}}, 1'b1} == lor_limit);

  assign coarse_change = coarse_nxt ^ coarse_r;
  assign fine_change = fine_nxt ^ fine_r;
  assign irq_event = {lor_event, coarse_change, fine_change};

  // ahb-lite slave, zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & (htrans == `PLM_HTRANS_NONSEQ || htrans == 2'b11);
  assign wr_data = hwdata;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      if (hready) begin
        wr_pend_r <= addr_phase & hwrite;
        wr_addr_r <= haddr[7:0];
      end
      if (addr_phase && !hwrite) begin
        case (reg_sel(haddr[7:0]))
          3'h1: hrdata <= ctrl_r;
          3'h2: hrdata <= {30'h0, fine_r, coarse_r};
          3'h3: hrdata <= {29'h0, irq_sts_r};
          3'h5: hrdata <= {29'h0, irq_en_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `PLM_CTRL_RST;
      irq_en_r <= `PLM_IRQ_EN_RST;
      irq_sts_r <= `PLM_IRQ_STS_RST;
    end else begin
      if (wr_pend_r && reg_sel(wr_addr_r) == 3'h1) begin
        ctrl_r <= wr_data & 32'h0000_00f3;
      end
      if (wr_pend_r && reg_sel(wr_addr_r) == 3'h5) begin
        irq_en_r <= wr_data[`PLM_IRQ_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      if (wr_pend_r && reg_sel(wr_addr_r) == 3'h4) begin
        irq_sts_r <= (irq_sts_r & ~wr_data[`PLM_IRQ_W-1:0]) | irq_event;
      end else begin
        irq_sts_r <= irq_sts_r | irq_event;
      end
    end
  end

  assign irq = |(irq_sts_r & irq_en_r);
  assign wake_req = irq_sts_r[`PLM_IRQ_LOSS_BIT] & irq_en_r[`PLM_IRQ_LOSS_BIT] & ~pll_power_down;
endmodule
`default_nettype wire

// [bench/plm_chk_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "plm_regs.vh"
module plm_chk #(
  parameter CNT_W = 7,
  parameter LOR_W = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ref_clk_in,
  input wire logic fb_clk_in,
  input wire logic pll_power_down,
  input wire logic coarse_lock_flag,
  input wire logic fine_lock_flag,
  input wire logic irq,
  input wire logic wake_req
);
  logic [7:0] since_ref_r;
  logic ref_d_r;
  // cycles since the reference input last moved
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since_ref_r <= 8'h00;
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= ref_clk_in;
      since_ref_r <= (ref_clk_in != ref_d_r) ? 8'h00 : since_ref_r + {7'h00, since_ref_r != 8'hff};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_addr(w, a);
    hsel && hready && htrans[1] && hwrite == w && haddr[7:0] == a;
  endsequence
  sequence s_ctrl_wr;
    s_addr(1'b1, `PLM_CTRL_OFS) ##1 1'b1;
  endsequence
  a_okay_resp: assert property (!hresp && hreadyout) else $error("bad bus response");
  a_rdata_holds: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_pdn_follows: assert property (s_ctrl_wr |=> pll_power_down == $past(hwdata[1]))
    else $error("power down not written");
  a_idle_disabled: assert property (s_addr(1'b1, `PLM_CTRL_OFS) ##1 !hwdata[0] |-> ##[1:2] (!coarse_lock_flag && !fine_lock_flag))
    else $error("flags kept while disabled");
  a_pdn_idle: assert property (pll_power_down && $past(pll_power_down) |-> !coarse_lock_flag && !fine_lock_flag)
    else $error("flags set while powered down");
  a_wake_gated: assert property (wake_req |-> irq && !pll_power_down) else $error("wake without cause");
  a_mask_irq: assert property (s_addr(1'b1, `PLM_IRQ_EN_OFS) ##1 hwdata[2:0] == 3'h0 |=> !irq && !wake_req)
    else $error("masked request still high");
  a_lock_fresh: assert property ($rose(coarse_lock_flag) || $rose(fine_lock_flag) |-> since_ref_r < 8'd16)
    else $error("lock set without reference");
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "plm_regs.vh"
module testbench;
  logic clk, rst_b, hsel, hwrite, ref_on, fast;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize, cnt, m6;
  wire [31:0] hrdata;
  wire hreadyout, hresp, pll_power_down, coarse_lock_flag, fine_lock_flag, irq, wake_req;
  wire ref_clk_in = ref_on & cnt[2];
  wire fb_clk_in = fast ? (m6 < 3'd3) : ref_clk_in;
  int errors, checked, n;
  plm_monitor plm_monitor_inst (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .ref_clk_in, .fb_clk_in, .pll_power_down, .coarse_lock_flag,
    .fine_lock_flag, .irq, .wake_req);
  task close_out;
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `PLM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cnt <= cnt + 3'd1;
    m6 <= (m6 == 3'd5) ? 3'd0 : m6 + 3'd1;
  end
  initial begin
    #20000;
    errors++;
    close_out;
  end
  initial begin
    {rst_b, hsel, hwrite, htrans, haddr, hwdata, ref_on, fast, cnt, m6} = '0;
    hsize = `PLM_HSIZE_WORD;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(`PLM_CTRL_OFS, `PLM_CTRL_RST);
    rd(`PLM_STAT_OFS, 0);
    rd(`PLM_IRQ_STS_OFS, 0);
    rd(`PLM_IRQ_EN_OFS, 0);
    rd(8'h40, 0);
    wr(`PLM_IRQ_EN_OFS, 7);
    wr(`PLM_CTRL_OFS, 32'hf1);
    ref_on <= 1'b1;
    // reference period is 8 clocks
    repeat (320) @(posedge clk);
    rd(`PLM_STAT_OFS, 1);
    repeat (240) @(posedge clk);
    rd(`PLM_STAT_OFS, 3);
    chk({30'h0, fine_lock_flag, coarse_lock_flag}, 3);
    chk(irq, 1);
    rd(`PLM_IRQ_STS_OFS, 3);
    fast <= 1'b1;
    repeat (144) @(posedge clk);
    rd(`PLM_STAT_OFS, 1);
    repeat (96) @(posedge clk);
    rd(`PLM_STAT_OFS, 0);
    wr(`PLM_IRQ_EN_OFS, 4);
    wr(`PLM_IRQ_CLR_OFS, 3);
    wr(`PLM_CTRL_OFS, 32'h11);
    ref_on <= 1'b0;
    n = 0;
    while (wake_req !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 30 && n <= 46, 1);
    rd(`PLM_IRQ_STS_OFS, 4);
    wr(`PLM_CTRL_OFS, 32'h12);
    @(negedge clk);
    chk(wake_req, 0);
    rd(`PLM_STAT_OFS, 0);
    wr(`PLM_IRQ_EN_OFS, 0);
    @(negedge clk);
    chk(irq, 0);
    wr(`PLM_IRQ_CLR_OFS, 4);
    rd(`PLM_IRQ_STS_OFS, 0);
    close_out;
  end
endmodule
bind plm_monitor plm_chk #(.CNT_W(CNT_W), .LOR_W(LOR_W)) plm_chk_inst (.clk, .rst_b, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .ref_clk_in, .fb_clk_in, .pll_power_down,
  .coarse_lock_flag, .fine_lock_flag, .irq, .wake_req);
`default_nettype wire
